// ### rtl/npd_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Identifier 30 is a 13-byte summary with two fp32 dilutions and five u8 counts at 8..12.
// - Identifier 31 carries a length equal to seven bytes times the satellites reported.
// - A satellite record holds system, number, frequency, elevation, u16 azimuth at 4, SNR at 6.
// - Satellite records repeat back to back with no separator until the payload is used up.
// - System codes are 0 unknown, 1 to 5 global and augmentation, 6 regional, 7 and 8 corrections.
// - The frequency mask has bit 0 unknown, 1-4 L1, 5-7 L2 and 8 L5, though only a byte arrives.
// - Identifier 32 is 24 bytes of latitude, longitude and height as fp64 at 0, 8 and 16.
// - Identifier 33 is 24 bytes of earth-centred X, Y and Z as fp64.
// - Identifier 34 is 25 bytes of northing, easting, height as fp64 and a signed zone at 24.
// - Identifier 35 is 12 bytes of north, east and down velocity as fp32.
// - Identifier 36 is 12 bytes of body X, Y and Z velocity as fp32 at 0, 4 and 8.
// - Identifier 37 is 12 bytes of X, Y and Z acceleration as fp32.
module npd_decoder
  import npd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Packet header from the framing layer.
  input wire logic hdr_valid_in,
  output logic hdr_ready_out,
  input wire npd_hdr_t hdr_in,
  // Payload bytes from the framing layer.
  input wire logic pay_valid_in,
  output logic pay_ready_out,
  input wire logic [BYTE_W-1:0] pay_data_in,
  // Decoded records.
  output logic rec_valid_out,
  input wire logic rec_ready_in,
  output npd_rec_t rec_out,
  // Events and status.
  output logic len_err_out,
  output logic unk_id_out,
  output logic busy_out
);

  typedef struct packed {
    npd_st_t st;
    npd_kind_t kind;
    logic [7:0] len;
    logic [7:0] got;
    logic [4:0] pos;
    logic [7:0] sat_idx;
    npd_buf_t buf_b;
    npd_rec_t rec;
    logic len_err;
    logic unk_id;
  } npd_state_t;

  npd_state_t st_ff;
  npd_state_t nxt_st;
  logic byte_valid;
  logic byte_take;
  logic [BYTE_W-1:0] byte_data;
  logic hdr_fire;
  logic id_known;
  logic len_good;
  npd_kind_t hdr_kind;
  logic [4:0] unit_last;

  // Payload bytes pass through a FIFO so the framer is stalled, not dropped, while a
  // record waits for its consumer.
  npd_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(pay_valid_in),
    .in_ready_out(pay_ready_out),
    .in_data_in(pay_data_in),
    .out_valid_out(byte_valid),
    .out_ready_in(byte_take),
    .out_data_out(byte_data)
  );

  // Little-endian assembly of multi-byte fields from the collected payload.
  function automatic logic [31:0] get32(input npd_buf_t b, input int off);
    return {b[off+3], b[off+2], b[off+1], b[off]};
  endfunction : get32

  function automatic logic [63:0] get64(input npd_buf_t b, input int off);
    return {get32(b, off + 4), get32(b, off)};
  endfunction : get64

  // Turn a filled buffer into a typed record.
  function automatic npd_rec_t decode(input npd_kind_t k, input npd_buf_t b,
                                      input logic [7:0] idx);
    npd_rec_t r;
    r = '0;
    r.kind = k;
    case (k)
      KIND_SUMMARY:
      begin
        r.sgl[0] = get32(b, OFF_HDOP);
        r.sgl[1] = get32(b, OFF_VDOP);
        for (int i = 0; i < NUM_CNT; i++)
          r.sat_cnt[i] = b[OFF_CNT0+i];
      end
      KIND_DETAIL:
      begin
        r.sat.sys_code = b[OFF_SYS];
        r.sat.sys_known = (b[OFF_SYS] <= SYS_CORR_B);
        r.sat.prn = b[OFF_PRN];
        // Only eight mask bits arrive; the L5 position stays clear.
        r.sat.freq = {1'b0, b[OFF_FREQ]};
        r.sat.elev = b[OFF_ELEV];
        r.sat.azim = {b[OFF_AZIM+1], b[OFF_AZIM]};
        r.sat.snr = b[OFF_SNR];
        r.sat.index = idx;
      end
      KIND_GEODETIC, KIND_ECEF, KIND_GRID:
      begin
        r.dbl[0] = get64(b, OFF_F64_0);
        r.dbl[1] = get64(b, OFF_F64_1);
        r.dbl[2] = get64(b, OFF_F64_2);
        if (k == KIND_GRID)
          r.zone = b[OFF_ZONE];
      end
      KIND_VEL_NED, KIND_VEL_BODY, KIND_ACCEL:
      begin
        r.sgl[0] = get32(b, OFF_F32_0);
        r.sgl[1] = get32(b, OFF_F32_1);
        r.sgl[2] = get32(b, OFF_F32_2);
      end
      default:
      begin
        r.kind = k;
      end
    endcase
    return r;
  endfunction : decode

  // Classify the header and check its length against the identifier.
  always_comb
  begin
    id_known = 1'b1;
    len_good = 1'b0;
    hdr_kind = KIND_SUMMARY;
    case (hdr_in.id)
      ID_SUMMARY:
      begin
        len_good = (hdr_in.len == LEN_SUMMARY);
      end
      ID_DETAIL:
      begin
        hdr_kind = KIND_DETAIL;
        len_good = ((hdr_in.len % SAT_REC_LEN) == 8'h00);
      end
      ID_GEODETIC:
      begin
        hdr_kind = KIND_GEODETIC;
        len_good = (hdr_in.len == LEN_POS);
      end
      ID_ECEF:
      begin
        hdr_kind = KIND_ECEF;
        len_good = (hdr_in.len == LEN_POS);
      end
      ID_GRID:
      begin
        hdr_kind = KIND_GRID;
        len_good = (hdr_in.len == LEN_GRID);
      end
      ID_VEL_NED:
      begin
        hdr_kind = KIND_VEL_NED;
        len_good = (hdr_in.len == LEN_VEC32);
      end
      ID_VEL_BODY:
      begin
        hdr_kind = KIND_VEL_BODY;
        len_good = (hdr_in.len == LEN_VEC32);
      end
      ID_ACCEL:
      begin
        hdr_kind = KIND_ACCEL;
        len_good = (hdr_in.len == LEN_VEC32);
      end
      default:
      begin
        id_known = 1'b0;
      end
    endcase
  end

  assign hdr_ready_out = (st_ff.st == ST_IDLE);
  assign hdr_fire = hdr_valid_in && hdr_ready_out;
  assign byte_take = byte_valid && ((st_ff.st == ST_COLLECT) || (st_ff.st == ST_DISCARD));
  // A detailed packet is cut into seven-byte units; others fill the buffer once.
  assign unit_last = (st_ff.kind == KIND_DETAIL) ? SAT_LAST_POS : 5'(st_ff.len - 8'h01);

  // Main sequencer: header, collect, emit, and discard of bad or foreign payloads.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.len_err = 1'b0;
    nxt_st.unk_id = 1'b0;
    case (st_ff.st)
      ST_IDLE:
      begin
        if (hdr_fire)
        begin
          nxt_st.kind = hdr_kind;
          nxt_st.len = hdr_in.len;
          nxt_st.got = 8'h00;
          nxt_st.pos = 5'h00;
          nxt_st.sat_idx = 8'h00;
          nxt_st.len_err = id_known && !len_good;
          nxt_st.unk_id = !id_known;
          if (hdr_in.len == 8'h00)
            nxt_st.st = ST_IDLE;
          else if (id_known && len_good)
            nxt_st.st = ST_COLLECT;
          else
            nxt_st.st = ST_DISCARD;
        end
      end
      ST_COLLECT:
      begin
        if (byte_take)
        begin
          nxt_st.buf_b[st_ff.pos] = byte_data;
          nxt_st.got = st_ff.got + 8'h01;
          nxt_st.pos = st_ff.pos + 5'h01;
          if (st_ff.pos == unit_last)
          begin
            nxt_st.rec = decode(st_ff.kind, nxt_st.buf_b, st_ff.sat_idx);
            nxt_st.st = ST_EMIT;
          end
        end
      end
      ST_EMIT:
      begin
        // The record holds still until the consumer takes it.
        if (rec_ready_in)
        begin
          nxt_st.pos = 5'h00;
          nxt_st.sat_idx = st_ff.sat_idx + 8'h01;
          if (st_ff.got == st_ff.len)
            nxt_st.st = ST_IDLE;
          else
            nxt_st.st = ST_COLLECT;
        end
      end
      ST_DISCARD:
      begin
        if (byte_take)
        begin
          nxt_st.got = st_ff.got + 8'h01;
          if (st_ff.got + 8'h01 == st_ff.len)
            nxt_st.st = ST_IDLE;
        end
      end
      default:
      begin
        nxt_st.st = ST_IDLE;
      end
    endcase
  end

  // State register; every field is zero after reset, which is the idle state.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register.
  assign rec_valid_out = (st_ff.st == ST_EMIT);
  assign rec_out = st_ff.rec;
  assign len_err_out = st_ff.len_err;
  assign unk_id_out = st_ff.unk_id;
  assign busy_out = (st_ff.st != ST_IDLE);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_summary_len: assert property (
    hdr_fire && hdr_in.id == ID_SUMMARY |=> len_err_out == $past(hdr_in.len != LEN_SUMMARY))
    else $error("summary length check wrong");
  a_detail_len: assert property (
    hdr_fire && hdr_in.id == ID_DETAIL && (hdr_in.len % SAT_REC_LEN) != 8'h00
    |=> len_err_out && st_ff.st == ST_DISCARD)
    else $error("detail length not multiple of record size");
  a_sat_azim_pos: assert property (
    st_ff.st == ST_COLLECT && st_ff.kind == KIND_DETAIL && byte_take && st_ff.pos == 5'h06
    |=> rec_valid_out && rec_out.sat.azim == {st_ff.buf_b[5], st_ff.buf_b[4]})
    else $error("azimuth taken from wrong bytes");
  a_rec_hold: assert property (
    rec_valid_out && !rec_ready_in |=> rec_valid_out && $stable(rec_out))
    else $error("record changed while stalled");
  a_sys_known: assert property (
    rec_valid_out && rec_out.kind == KIND_DETAIL
    |-> rec_out.sat.sys_known == (rec_out.sat.sys_code <= SYS_CORR_B))
    else $error("system code validity wrong");
  a_freq_l5_clear: assert property (
    rec_valid_out && rec_out.kind == KIND_DETAIL |-> !rec_out.sat.freq[FREQ_L5])
    else $error("L5 bit set without source");
  a_geo_len: assert property (
    hdr_fire && hdr_in.id == ID_GEODETIC && hdr_in.len != LEN_POS |=> len_err_out ##1 !len_err_out)
    else $error("geodetic length error not one pulse");
  a_ecef_len: assert property (
    hdr_fire && hdr_in.id == ID_ECEF && hdr_in.len == LEN_POS |=> st_ff.st == ST_COLLECT)
    else $error("earth-centred packet not collected");
  a_grid_len: assert property (
    hdr_fire && hdr_in.id == ID_GRID |=> len_err_out == $past(hdr_in.len != LEN_GRID))
    else $error("grid length check wrong");
  a_vec_len: assert property (
    hdr_fire && (hdr_in.id == ID_VEL_NED || hdr_in.id == ID_VEL_BODY || hdr_in.id == ID_ACCEL)
    |=> len_err_out == $past(hdr_in.len != LEN_VEC32))
    else $error("vector length check wrong");
  a_discard_quiet: assert property (
    st_ff.st == ST_DISCARD |=> !rec_valid_out)
    else $error("record emitted from discarded payload");

  c_summary: cover property (rec_valid_out && rec_ready_in && rec_out.kind == KIND_SUMMARY);
  c_two_sats: cover property (rec_valid_out && rec_out.kind == KIND_DETAIL
    && rec_out.sat.index == 8'h01);
  c_grid: cover property (rec_valid_out && rec_out.kind == KIND_GRID);
  c_len_err: cover property (len_err_out);

endmodule : npd_decoder

// ### rtl/npd_fifo.sv
`timescale 1ns/1ps
module npd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Filling side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic push;
  logic pop_mem;

  // The output word sits in a register, so the memory count excludes it.
  assign in_ready_out = (st_ff.cnt != FULL_CNT);
  assign push = in_valid_in && in_ready_out;
  assign pop_mem = (st_ff.cnt != '0) && (!st_ff.ov || out_ready_in);
  assign out_valid_out = st_ff.ov;
  assign out_data_out = st_ff.od;

  // Write, refill the output stage, and keep the count honest.
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data_in;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop_mem)
    begin
      nxt_st.od = st_ff.mem[st_ff.rp];
      nxt_st.rp = st_ff.rp + 1'b1;
      nxt_st.ov = 1'b1;
    end
    else if (out_ready_in)
    begin
      nxt_st.ov = 1'b0;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop_mem);
  end

  // State register.
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  a_fifo_full_stall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    in_valid_in && !in_ready_out |=> $stable(st_ff.wp))
    else $error("fifo accepted a word while full");
  a_fifo_count_bound: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_ff.cnt <= FULL_CNT)
    else $error("fifo count beyond depth");

endmodule : npd_fifo

// ### rtl/npd_pkg.sv
package npd_pkg;

  // Byte and framing widths.
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int MAX_LEN = 25;

  // Packet identifiers as delivered by the framing layer.
  localparam logic [7:0] ID_SUMMARY = 8'h1e;
  localparam logic [7:0] ID_DETAIL = 8'h1f;
  localparam logic [7:0] ID_GEODETIC = 8'h20;
  localparam logic [7:0] ID_ECEF = 8'h21;
  localparam logic [7:0] ID_GRID = 8'h22;
  localparam logic [7:0] ID_VEL_NED = 8'h23;
  localparam logic [7:0] ID_VEL_BODY = 8'h24;
  localparam logic [7:0] ID_ACCEL = 8'h25;

  // Fixed payload lengths in bytes.
  localparam logic [7:0] LEN_SUMMARY = 8'h0d;
  localparam logic [7:0] LEN_POS = 8'h18;
  localparam logic [7:0] LEN_GRID = 8'h19;
  localparam logic [7:0] LEN_VEC32 = 8'h0c;
  localparam logic [7:0] SAT_REC_LEN = 8'h07;
  localparam logic [4:0] SAT_LAST_POS = 5'h06;

  // Field offsets inside a payload or a satellite record.
  localparam int OFF_HDOP = 0;
  localparam int OFF_VDOP = 4;
  localparam int OFF_CNT0 = 8;
  localparam int NUM_CNT = 5;
  localparam int OFF_F64_0 = 0;
  localparam int OFF_F64_1 = 8;
  localparam int OFF_F64_2 = 16;
  localparam int OFF_ZONE = 24;
  localparam int OFF_F32_0 = 0;
  localparam int OFF_F32_1 = 4;
  localparam int OFF_F32_2 = 8;
  localparam int OFF_SYS = 0;
  localparam int OFF_PRN = 1;
  localparam int OFF_FREQ = 2;
  localparam int OFF_ELEV = 3;
  localparam int OFF_AZIM = 4;
  localparam int OFF_SNR = 6;

  // Satellite system codes.
  localparam logic [7:0] SYS_UNKNOWN = 8'h00;
  localparam logic [7:0] SYS_GPS = 8'h01;
  localparam logic [7:0] SYS_GLONASS = 8'h02;
  localparam logic [7:0] SYS_BEIDOU = 8'h03;
  localparam logic [7:0] SYS_GALILEO = 8'h04;
  localparam logic [7:0] SYS_SBAS = 8'h05;
  localparam logic [7:0] SYS_QZSS = 8'h06;
  localparam logic [7:0] SYS_CORR_A = 8'h07;
  localparam logic [7:0] SYS_CORR_B = 8'h08;

  // Frequency mask bit positions.
  localparam int FREQ_UNKNOWN = 0;
  localparam int FREQ_L1_CA = 1;
  localparam int FREQ_L1_C = 2;
  localparam int FREQ_L1_P = 3;
  localparam int FREQ_L1_M = 4;
  localparam int FREQ_L2_C = 5;
  localparam int FREQ_L2_P = 6;
  localparam int FREQ_L2_M = 7;
  localparam int FREQ_L5 = 8;
  localparam int FREQ_W = 9;

  typedef enum logic [2:0] {
    KIND_SUMMARY,
    KIND_DETAIL,
    KIND_GEODETIC,
    KIND_ECEF,
    KIND_GRID,
    KIND_VEL_NED,
    KIND_VEL_BODY,
    KIND_ACCEL
  } npd_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_EMIT,
    ST_DISCARD
  } npd_st_t;

  typedef logic [MAX_LEN-1:0][BYTE_W-1:0] npd_buf_t;

  typedef struct packed {
    logic [7:0] id;
    logic [7:0] len;
  } npd_hdr_t;

  typedef struct packed {
    logic [7:0] sys_code;
    logic sys_known;
    logic [7:0] prn;
    logic [FREQ_W-1:0] freq;
    logic [7:0] elev;
    logic [15:0] azim;
    logic [7:0] snr;
    logic [7:0] index;
  } npd_sat_t;

  typedef struct packed {
    npd_kind_t kind;
    logic [2:0][63:0] dbl;
    logic [2:0][31:0] sgl;
    logic [NUM_CNT-1:0][7:0] sat_cnt;
    logic signed [7:0] zone;
    npd_sat_t sat;
  } npd_rec_t;

endpackage : npd_pkg

// ### verif/nav_packet_payload_decoder_bench.sv
`timescale 1ns/1ps
module nav_packet_payload_decoder_bench;
  import npd_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hdr_valid, hdr_ready, pay_valid, pay_ready, rec_valid, len_err, unk_id, busy, done;
  logic rec_ready = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic saw_full = 1'b0;
  npd_hdr_t hdr;
  npd_hdr_t hdr_req = '0;
  logic [7:0] pay_data;
  npd_rec_t rec;
  logic [255:0][7:0] bytes = '0;
  npd_rec_t rec_q[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_len_err = 0;
  int n_unk = 0;
  int seed = 32'h15bb;

  // A 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  npd_decoder uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hdr_valid_in(hdr_valid),
    .hdr_ready_out(hdr_ready), .hdr_in(hdr), .pay_valid_in(pay_valid),
    .pay_ready_out(pay_ready), .pay_data_in(pay_data), .rec_valid_out(rec_valid),
    .rec_ready_in(rec_ready), .rec_out(rec), .len_err_out(len_err), .unk_id_out(unk_id),
    .busy_out(busy));

  npd_framer_model far (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start),
    .hdr_req_in(hdr_req), .bytes_in(bytes), .slow_in(slow), .done_out(done),
    .hdr_valid_out(hdr_valid), .hdr_ready_in(hdr_ready), .hdr_out(hdr),
    .pay_valid_out(pay_valid), .pay_ready_in(pay_ready), .pay_data_out(pay_data));

  // Records and event pulses are logged; the consumer stalls at random, or fully until the
  // buffer refuses, so that the full case is reached without a deadlock.
  always @(posedge clk_in)
  begin
    if (rec_valid && rec_ready) rec_q.push_back(rec);
    if (len_err) n_len_err++;
    if (unk_id) n_unk++;
    if (!sys_rst_in && !pay_ready) saw_full <= 1'b1;
    if (!sys_rst_in && !pay_ready) hold <= 1'b0;
    rec_ready <= !hold && ($random(seed) % 4 != 0);
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Little-endian gather: the lowest offset is the least significant byte.
  function automatic logic [63:0] le(input int off, input int n);
    le = '0;
    for (int i = 0; i < n; i++) le[8*i +: 8] = bytes[off+i];
  endfunction : le

  function automatic logic [7:0] fixed_len(input logic [7:0] id);
    case (id)
      ID_SUMMARY: fixed_len = LEN_SUMMARY;
      ID_GEODETIC, ID_ECEF: fixed_len = LEN_POS;
      ID_GRID: fixed_len = LEN_GRID;
      default: fixed_len = LEN_VEC32;
    endcase
  endfunction : fixed_len

  task automatic check_rec(input logic [7:0] id, input int k, input npd_rec_t r);
    int o;
    o = 7 * k;
    chk("kind", 64'(3'(id - ID_SUMMARY)), 64'(r.kind));
    case (id)
      ID_SUMMARY:
      begin
        for (int j = 0; j < 2; j++) chk("dilution", le(4*j, 4), r.sgl[j]);
        for (int j = 0; j < NUM_CNT; j++) chk("count", bytes[OFF_CNT0+j], r.sat_cnt[j]);
      end
      ID_DETAIL:
      begin
        chk("sat index", 64'(k), r.sat.index);
        chk("system code", bytes[o], r.sat.sys_code);
        chk("system known", bytes[o] <= SYS_CORR_B, r.sat.sys_known);
        chk("sat number", bytes[o+1], r.sat.prn);
        chk("freq mask", {1'b0, bytes[o+2]}, r.sat.freq);
        chk("elevation", bytes[o+3], r.sat.elev);
        chk("azimuth", le(o+4, 2), r.sat.azim);
        chk("snr", bytes[o+6], r.sat.snr);
      end
      ID_GEODETIC, ID_ECEF, ID_GRID:
      begin
        for (int j = 0; j < 3; j++) chk("fp64 field", le(8*j, 8), r.dbl[j]);
        if (id == ID_GRID) chk("zone", bytes[OFF_ZONE], $unsigned(r.zone));
      end
      default:
        for (int j = 0; j < 3; j++) chk("fp32 field", le(4*j, 4), r.sgl[j]);
    endcase
  endtask : check_rec

  // Sends one packet through the framer model, waits for idle, then checks all outcomes.
  task automatic run_pkt(input logic [7:0] id, input logic [7:0] len, input string name);
    int le0;
    int un0;
    int i;
    logic known;
    logic bad;
    le0 = n_len_err;
    un0 = n_unk;
    rec_q.delete();
    known = (id >= ID_SUMMARY) && (id <= ID_ACCEL);
    bad = known && ((id == ID_DETAIL) ? (len % 7 != 0) : (len != fixed_len(id)));
    hdr_req <= '{id: id, len: len};
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    for (i = 0; i < 4000 && !(i > 1 && done && !busy); i++) @(posedge clk_in);
    if (i == 4000)
    begin
      n_mismatch++;
      $display("ERROR idle wait expected 1 seen 0");
      final_report();
    end
    chk("length error pulses", 64'(bad), 64'(n_len_err - le0));
    chk("unknown id pulses", 64'(!known), 64'(n_unk - un0));
    chk("records", (!known || bad) ? 0 : (id == ID_DETAIL ? len / 7 : 1), rec_q.size());
    for (i = 0; i < rec_q.size(); i++) check_rec(id, i, rec_q[i]);
    $display("Test %s id %0d len %0d done", name, id, len);
  endtask : run_pkt

  initial
  begin
    logic [7:0] id;
    logic [7:0] n;
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    // Every identifier with a good length; the first round walks system codes 0 to 9.
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 8; i++)
      begin
        id = ID_SUMMARY + 8'(i);
        n = (r == 0) ? 8'd10 : 8'(1 + {$random(seed)} % 5);
        for (int b = 0; b < 256; b++) bytes[b] = 8'($random(seed));
        for (int k = 0; k < n && r == 0; k++) bytes[7*k] = 8'(k);
        slow <= r[0];
        run_pkt(id, (id == ID_DETAIL) ? 8'(7 * n) : fixed_len(id), "good length");
      end
    // Wrong lengths, one above or below the fixed figure, and eight for the detailed kind.
    for (int i = 0; i < 8; i++)
    begin
      id = ID_SUMMARY + 8'(i);
      n = (i % 2 == 0) ? fixed_len(id) + 8'd1 : fixed_len(id) - 8'd1;
      run_pkt(id, (id == ID_DETAIL) ? 8'd8 : n, "length error");
    end
    // Identifiers just outside the decoded range and far from it.
    run_pkt(8'h1d, 8'd5, "unknown id");
    run_pkt(8'h26, 8'd5, "unknown id");
    run_pkt(8'hff, 8'd5, "unknown id");
    // Largest detailed packet with the consumer stalled until the buffer refuses.
    saw_full <= 1'b0;
    hold <= 1'b1;
    slow <= 1'b0;
    @(posedge clk_in);
    run_pkt(ID_DETAIL, 8'd252, "buffer full");
    chk("buffer refused", 64'h1, 64'(saw_full));
    final_report();
  end
endmodule : nav_packet_payload_decoder_bench

// ### verif/npd_framer_model.sv
`timescale 1ns/1ps
module npd_framer_model
  import npd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Orders from the bench.
  input wire logic start_in,
  input wire npd_hdr_t hdr_req_in,
  input wire logic [255:0][7:0] bytes_in,
  input wire logic slow_in,
  output logic done_out,
  // Framing side towards the decoder.
  output logic hdr_valid_out,
  input wire logic hdr_ready_in,
  output npd_hdr_t hdr_out,
  output logic pay_valid_out,
  input wire logic pay_ready_in,
  output logic [BYTE_W-1:0] pay_data_out
);
  int seed = 32'h2f41;
  int i;

  // One packet per order: the header first, then exactly the announced number of bytes.
  initial
  begin
    done_out = 1'b1;
    hdr_valid_out = 1'b0;
    hdr_out = '0;
    pay_valid_out = 1'b0;
    pay_data_out = 8'h5a;
    forever
    begin
      @(posedge clk_in);
      if (start_in && !sys_rst_in)
      begin
        done_out <= 1'b0;
        hdr_valid_out <= 1'b1;
        hdr_out <= hdr_req_in;
        do @(posedge clk_in); while (!hdr_ready_in);
        hdr_valid_out <= 1'b0;
        hdr_out <= ~hdr_req_in;
        for (i = 0; i < int'(hdr_req_in.len); i++)
        begin
          // Gaps are random; a released data line shows a changed value, not the last one.
          if (slow_in && ($random(seed) % 2 != 0))
          begin
            pay_valid_out <= 1'b0;
            pay_data_out <= ~pay_data_out;
            @(posedge clk_in);
          end
          pay_valid_out <= 1'b1;
          pay_data_out <= bytes_in[i];
          do @(posedge clk_in); while (!pay_ready_in);
        end
        pay_valid_out <= 1'b0;
        pay_data_out <= ~pay_data_out;
        done_out <= 1'b1;
      end
    end
  end
endmodule : npd_framer_model
